// ### include/dma_chan_pkg.sv
// dma channel control package: register offsets, bit positions, resets
// and the packed carriers shared by the channel control files.
// assumes an 8-bit peripheral bus byte address and 32-bit data.
package dma_chan_pkg;

  // byte offsets of the channel registers
  localparam logic [7:0] OFS_TIME = 8'h14;
  localparam logic [7:0] OFS_CTRL = 8'h20;
  localparam logic [7:0] OFS_LEN  = 8'h24;
  localparam logic [7:0] OFS_TXD  = 8'h28;
  localparam logic [7:0] OFS_RXD  = 8'h2c;
  localparam logic [7:0] OFS_ADDR = 8'h30;

  // channel control/status bit positions
  localparam int BIT_HALT   = 16;
  localparam int BIT_PID    = 15;
  localparam int BIT_HDR    = 14;
  localparam int BIT_EN     = 13;
  localparam int BIT_HOLD   = 12;
  localparam int BIT_RD     = 11;
  localparam int BIT_RX     = 10;
  localparam int BIT_ABORT  = 9;
  localparam int BIT_INERR  = 8;
  localparam int BIT_OUTERR = 7;
  localparam int BIT_PKTIN  = 6;
  localparam int BIT_PKTOUT = 5;
  localparam int BIT_ERRIE  = 4;
  localparam int BIT_RXIE   = 3;
  localparam int BIT_TXIE   = 2;
  localparam int BIT_ACCEPT = 1;
  localparam int BIT_KICK   = 0;

  // field positions in the other registers
  localparam int TIME_FLAG_LSB = 6;
  localparam int LEN_LSB       = 2;
  localparam int BASE_LSB      = 10;
  localparam int TXIDX_LSB     = 4;
  localparam int RXIDX_LSB     = 3;
  localparam int MASK_LSB      = 8;

  // reset values
  localparam logic [7:0] ADDR_RST = 8'hfe;
  localparam logic [7:0] MASK_RST = 8'h00;

  typedef struct packed {
    logic [1:0] flags;
    logic [5:0] count;
  } time_code_t;

  // events reported by the dma engines and the link, same clock
  typedef struct packed {
    logic rx_pkt;
    logic tx_pkt;
    logic rx_err;
    logic tx_err;
    logic link_err;
    logic tx_desc_read;
    logic tx_desc_off;
    logic rx_desc_read;
    logic rx_desc_off;
    logic rx_active;
  } dma_event_t;

  // controls handed to the dma engines
  typedef struct packed {
    logic tx_enable;
    logic rx_enable;
    logic abort;
    logic strip_first;
    logic strip_second;
    logic discard_no_desc;
    logic rx_desc_ready;
  } dma_ctrl_t;

endpackage

// ### src/dma_channel_ctrl.sv
// dma channel control: time-code register and one dma channel's registers
// on the peripheral bus. assumes the dma engines, codec and bus master
// share CLK; only TICK_IN comes from a pin and is synchronised.
//
// How it works
// (R1) two time flags go out with ticks; received codes overwrite them
// (R2) each tick increments time_count and sends the incremented value; a tick that meets a received code or a write is dropped
// (R3) software writes to time_count store silently; received counts store
// (R4) link error with halt_tx_on_link_fault set drops the transmit enable
// (R5) drop_protocol_id_byte strips bytes one and two of each packet
// (R6) drop_address_byte strips the first byte of each packet
// (R7) own_node_match_select picks channel address and mask over node-wide
// (R8) hold_when_no_descriptor clear discards, set waits for a descriptor
// (R9) rx_descriptors_ready set by software, cleared on disabled descriptor
// (R10) reception_in_progress reads the live receive activity
// (R11) abort_transmit ends the packet, disables transmit, self clears
// (R12) bus errors on receive or transmit set sticky write-one-clear flags
// (R13) packet_in_flag and packet_out_flag set per packet, software clears
// (R14) enabled interrupts pulse on bus errors and packets; enables unreset
// (R15) packets are stored only while inbound_accept_on is one
// (R16) tx_kick set by software, cleared on reaching disabled descriptor
// (R17) max_inbound_length is 25 bits, low two bits zero, not reset
// (R18) transmit table_index steps 16 bytes per read and wraps to zero
// (R19) receive table_index steps 8 bytes per read and wraps to zero
// (R20) address check ands both addresses with inverted mask; reset 254
// (R21) a tick is sent once the current character has finished
// (R22) reserved bits read zero and ignore writes
`timescale 1ns/100ps
module dma_channel_ctrl
  import dma_chan_pkg::*;
(
  // clock, reset, enable
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        CE,
  // peripheral bus slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic [31:0]      PRDATA,
  // time-codes
  input  wire logic        TICK_IN,
  input  wire logic        SW_TICK,
  input  wire logic        CHAR_DONE,
  input  wire logic        RX_TC_VALID,
  input  time_code_t       RX_TC,
  output logic             TC_SEND,
  output time_code_t       TC_DATA,
  // dma engines
  input  dma_event_t       EVT,
  output dma_ctrl_t        CTRL,
  output logic [24:0]      MAX_LEN,
  output logic [31:0]      TX_DESC_ADDR,
  output logic [31:0]      RX_DESC_ADDR,
  // node address check
  input  wire logic [7:0]  RX_ADDR,
  input  wire logic [7:0]  NODE_ADDR,
  input  wire logic [7:0]  NODE_MASK,
  output logic             ADDR_MATCH,
  // interrupt pulse
  output logic             IRQ
);

  logic        take;
  logic        wr;
  logic        wr_time;
  logic        wr_ctrl;
  logic        wr_len;
  logic        wr_txd;
  logic        wr_rxd;
  logic        wr_addr;
  logic        mapped;
  logic [31:0] rdata;
  logic        tick_s;
  logic        tick_prev_q;
  logic        tick_now;

  time_code_t  tc_q,   tc_d;
  time_code_t  tcout_q, tcout_d;
  logic        pend_q, pend_d;
  logic        send_q, send_d;

  logic        halt_q, halt_d;
  logic        pid_q, pid_d;
  logic        hdr_q, hdr_d;
  logic        en_q, en_d;
  logic        hold_q, hold_d;
  logic        rd_q, rd_d;
  logic        abort_q, abort_d;
  logic        accept_q, accept_d;
  logic        kick_q, kick_d;
  logic        inerr_q, outerr_q, pktin_q, pktout_q;
  logic [2:0]  irqen_q, irqen_d;
  logic [22:0] len_q,   len_d;
  logic [21:0] txb_q,   txb_d;
  logic [5:0]  txi_q,   txi_d;
  logic [21:0] rxb_q,   rxb_d;
  logic [6:0]  rxi_q,   rxi_d;
  logic [7:0]  adr_q,   adr_d;
  logic [7:0]  msk_q,   msk_d;
  logic        match_d;
  logic        irq_d;
  dma_ctrl_t   ctrl_d;

  // bus access is taken in the first enable cycle, answered one later
  assign take    = CE && PSEL && PENABLE && !PREADY;
  assign wr      = take && PWRITE;
  assign wr_time = wr && (PADDR == OFS_TIME);
  assign wr_ctrl = wr && (PADDR == OFS_CTRL);
  assign wr_len  = wr && (PADDR == OFS_LEN);
  assign wr_txd  = wr && (PADDR == OFS_TXD);
  assign wr_rxd  = wr && (PADDR == OFS_RXD);
  assign wr_addr = wr && (PADDR == OFS_ADDR);

  // tick pin is asynchronous, so it is synchronised before edge detection
  sync2 #(.W(1)) u_tick_sync (
    .clk (CLK),
    .rst (RST),
    .ce  (CE),
    .d   (TICK_IN),
    .q   (tick_s)
  );
  assign tick_now = (tick_s && !tick_prev_q) || SW_TICK;

  // time-code state; a received code wins over a write and a tick
  always_comb begin
    tc_d    = tc_q;
    tcout_d = tcout_q;
    pend_d  = pend_q;
    send_d  = 1'b0;
    if (CE) begin
      // (R21) send after character
      if (pend_q && CHAR_DONE) begin
        send_d = 1'b1;
        pend_d = 1'b0;
      end
      if (RX_TC_VALID) begin
        // (R1) store received flags
        tc_d = RX_TC;
      end else if (wr_time) begin
        // (R3) silent software write
        tc_d.flags = PWDATA[TIME_FLAG_LSB +: 2];
        tc_d.count = PWDATA[5:0];
      end else if (tick_now) begin
        // (R2) increment and send
        tc_d.count    = tc_q.count + 6'h01;
        tcout_d.flags = tc_q.flags;
        tcout_d.count = tc_q.count + 6'h01;
        pend_d        = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      tc_q        <= '0;
      tcout_q     <= '0;
      pend_q      <= 1'b0;
      send_q      <= 1'b0;
      tick_prev_q <= 1'b0;
    end else begin
      tc_q        <= tc_d;
      tcout_q     <= tcout_d;
      pend_q      <= pend_d;
      send_q      <= send_d;
      tick_prev_q <= CE ? tick_s : tick_prev_q;
    end
  end
  assign TC_SEND = send_q;
  assign TC_DATA = tcout_q;

  // channel control bits; hardware clears lose to a software set
  always_comb begin
    {halt_d, pid_d, hdr_d, en_d, hold_d} =
      {halt_q, pid_q, hdr_q, en_q, hold_q};
    rd_d     = rd_q;
    accept_d = accept_q;
    kick_d   = kick_q;
    abort_d  = 1'b0;
    if (CE) begin
      // (R9) clear on disabled descriptor
      if (EVT.rx_desc_off) begin
        rd_d = 1'b0;
      end
      // (R16) clear on disabled descriptor
      if (EVT.tx_desc_off) begin
        kick_d = 1'b0;
      end
      // (R4) halt on link fault
      if (halt_q && EVT.link_err) begin
        kick_d = 1'b0;
      end
      if (wr_ctrl) begin
        halt_d   = PWDATA[BIT_HALT];
        pid_d    = PWDATA[BIT_PID];
        hdr_d    = PWDATA[BIT_HDR];
        en_d     = PWDATA[BIT_EN];
        hold_d   = PWDATA[BIT_HOLD];
        accept_d = PWDATA[BIT_ACCEPT];
        if (PWDATA[BIT_RD]) begin
          rd_d = 1'b1;
        end
        if (PWDATA[BIT_KICK]) begin
          kick_d = 1'b1;
        end
        // (R11) abort wins, self clearing
        if (PWDATA[BIT_ABORT]) begin
          abort_d = 1'b1;
          kick_d  = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      {halt_q, pid_q, hdr_q, en_q, hold_q} <= 5'h00;
      rd_q     <= 1'b0;
      accept_q <= 1'b0;
      kick_q   <= 1'b0;
      abort_q  <= 1'b0;
    end else begin
      {halt_q, pid_q, hdr_q, en_q, hold_q} <=
        {halt_d, pid_d, hdr_d, en_d, hold_d};
      rd_q     <= rd_d;
      accept_q <= accept_d;
      kick_q   <= kick_d;
      abort_q  <= abort_d;
    end
  end

  // (R12) bus error flags
  sticky_flag u_inerr (
    .clk (CLK), .rst (RST), .ce (CE),
    .set (EVT.rx_err), .clr (wr_ctrl && PWDATA[BIT_INERR]), .q (inerr_q)
  );
  sticky_flag u_outerr (
    .clk (CLK), .rst (RST), .ce (CE),
    .set (EVT.tx_err), .clr (wr_ctrl && PWDATA[BIT_OUTERR]), .q (outerr_q)
  );
  // (R13) packet flags
  sticky_flag u_pktin (
    .clk (CLK), .rst (RST), .ce (CE),
    .set (EVT.rx_pkt), .clr (wr_ctrl && PWDATA[BIT_PKTIN]), .q (pktin_q)
  );
  sticky_flag u_pktout (
    .clk (CLK), .rst (RST), .ce (CE),
    .set (EVT.tx_pkt), .clr (wr_ctrl && PWDATA[BIT_PKTOUT]), .q (pktout_q)
  );

  // unreset fields: enables, length, table bases; software must load them
  always_comb begin
    irqen_d = irqen_q;
    len_d   = len_q;
    txb_d   = txb_q;
    rxb_d   = rxb_q;
    if (wr_ctrl) begin
      irqen_d = {PWDATA[BIT_ERRIE], PWDATA[BIT_RXIE], PWDATA[BIT_TXIE]};
    end
    // (R17) only bits 24..2 writable
    if (wr_len) begin
      len_d = PWDATA[LEN_LSB +: 23];
    end
    if (wr_txd) begin
      txb_d = PWDATA[BASE_LSB +: 22];
    end
    if (wr_rxd) begin
      rxb_d = PWDATA[BASE_LSB +: 22];
    end
  end

  always_ff @(posedge CLK) begin
    irqen_q <= irqen_d;
    len_q   <= len_d;
    txb_q   <= txb_d;
    rxb_q   <= rxb_d;
  end

  // descriptor selectors step one entry per read and wrap by width
  always_comb begin
    txi_d = txi_q;
    rxi_d = rxi_q;
    adr_d = adr_q;
    msk_d = msk_q;
    if (CE) begin
      // (R18) transmit index steps
      if (wr_txd) begin
        txi_d = PWDATA[TXIDX_LSB +: 6];
      end else if (EVT.tx_desc_read) begin
        txi_d = txi_q + 6'h01;
      end
      // (R19) receive index steps
      if (wr_rxd) begin
        rxi_d = PWDATA[RXIDX_LSB +: 7];
      end else if (EVT.rx_desc_read) begin
        rxi_d = rxi_q + 7'h01;
      end
      if (wr_addr) begin
        adr_d = PWDATA[7:0];
        msk_d = PWDATA[MASK_LSB +: 8];
      end
    end
  end

  // (R20) masked compare, (R7) own or node-wide address
  always_comb begin
    if (en_q) begin
      match_d = (RX_ADDR & ~msk_q) == (adr_q & ~msk_q);
    end else begin
      match_d = (RX_ADDR & ~NODE_MASK) == (NODE_ADDR & ~NODE_MASK);
    end
  end

  // (R14) interrupt pulse from enabled events
  always_comb begin
    irq_d = (irqen_q[2] && (EVT.rx_err || EVT.tx_err)) ||
            (irqen_q[1] && EVT.rx_pkt) ||
            (irqen_q[0] && EVT.tx_pkt);
  end

  // controls to the engines, registered from their next values
  always_comb begin
    ctrl_d.tx_enable       = kick_d;
    // (R15) store only while accepting
    ctrl_d.rx_enable       = accept_d;
    ctrl_d.abort           = abort_d;
    // (R5) (R6) byte stripping
    ctrl_d.strip_first     = hdr_d || pid_d;
    ctrl_d.strip_second    = pid_d;
    // (R8) discard unless holding
    ctrl_d.discard_no_desc = !hold_d;
    ctrl_d.rx_desc_ready   = rd_d;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      txi_q      <= 6'h00;
      rxi_q      <= 7'h00;
      adr_q      <= ADDR_RST;
      msk_q      <= MASK_RST;
      ADDR_MATCH <= 1'b0;
      IRQ        <= 1'b0;
      CTRL       <= '0;
    end else begin
      txi_q      <= txi_d;
      rxi_q      <= rxi_d;
      adr_q      <= adr_d;
      msk_q      <= msk_d;
      ADDR_MATCH <= CE ? match_d : ADDR_MATCH;
      IRQ        <= CE ? irq_d : IRQ;
      CTRL       <= ctrl_d;
    end
  end
  assign MAX_LEN      = {len_q, 2'b00};
  assign TX_DESC_ADDR = {txb_q, txi_q, 4'h0};
  assign RX_DESC_ADDR = {rxb_q, rxi_q, 3'h0};

  // read mux; (R22) reserved bits read zero
  always_comb begin
    rdata  = 32'h0000_0000;
    mapped = 1'b1;
    unique case (PADDR)
      OFS_TIME: rdata[7:0] = tc_q;
      OFS_CTRL: begin
        rdata[BIT_HALT]   = halt_q;
        rdata[BIT_PID]    = pid_q;
        rdata[BIT_HDR]    = hdr_q;
        rdata[BIT_EN]     = en_q;
        rdata[BIT_HOLD]   = hold_q;
        rdata[BIT_RD]     = rd_q;
        // (R10) live activity
        rdata[BIT_RX]     = EVT.rx_active;
        rdata[BIT_INERR]  = inerr_q;
        rdata[BIT_OUTERR] = outerr_q;
        rdata[BIT_PKTIN]  = pktin_q;
        rdata[BIT_PKTOUT] = pktout_q;
        rdata[BIT_ERRIE]  = irqen_q[2];
        rdata[BIT_RXIE]   = irqen_q[1];
        rdata[BIT_TXIE]   = irqen_q[0];
        rdata[BIT_ACCEPT] = accept_q;
        rdata[BIT_KICK]   = kick_q;
      end
      OFS_LEN:  rdata[24:0] = {len_q, 2'b00};
      OFS_TXD:  rdata[31:4] = {txb_q, txi_q};
      OFS_RXD:  rdata[31:3] = {rxb_q, rxi_q};
      OFS_ADDR: rdata[15:0] = {msk_q, adr_q};
      default:  mapped = 1'b0;
    endcase
  end

  // answer one cycle after the take; unmapped gives an error, zero data
  always_ff @(posedge CLK) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else if (CE) begin
      PREADY  <= take;
      PSLVERR <= take && !mapped;
      PRDATA  <= (take && !PWRITE) ? rdata : 32'h0000_0000;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  property p_tick_inc;
    (CE && tick_now && !RX_TC_VALID && !wr_time) |=>
      (tc_q.count == $past(tc_q.count) + 6'h01) && pend_q &&
      (TC_DATA.count == tc_q.count);
  endproperty
  a_tick_inc: assert property (p_tick_inc) // (R2)
    else $error("tick did not increment and queue the count");

  property p_send_wait;
    (pend_q && !CHAR_DONE) |=> !TC_SEND;
  endproperty
  a_send_wait: assert property (p_send_wait) // (R21)
    else $error("time-code sent before character end");

  property p_rx_store;
    (CE && RX_TC_VALID) |=>
      (tc_q == $past(RX_TC)) && (!pend_q || $past(pend_q));
  endproperty
  a_rx_store: assert property (p_rx_store) // (R1)
    else $error("received time-code not stored");

  property p_abort;
    (CE && wr_ctrl && PWDATA[BIT_ABORT]) |=>
      (!kick_q && abort_q) ##1 !abort_q;
  endproperty
  a_abort: assert property (p_abort) // (R11)
    else $error("abort did not disable and self clear");

  property p_link_halt;
    (CE && halt_q && EVT.link_err && !wr_ctrl) |=>
      !kick_q && !CTRL.tx_enable;
  endproperty
  a_link_halt: assert property (p_link_halt) // (R4)
    else $error("transmit still enabled after link fault");

  property p_txidx;
    (CE && EVT.tx_desc_read && !wr_txd) |=>
      TX_DESC_ADDR[9:0] == $past(TX_DESC_ADDR[9:0]) + 10'h010;
  endproperty
  a_txidx: assert property (p_txidx) // (R18)
    else $error("transmit index did not step by 16");

  property p_rxidx;
    (CE && EVT.rx_desc_read && !wr_rxd) |=>
      RX_DESC_ADDR[9:0] == $past(RX_DESC_ADDR[9:0]) + 10'h008;
  endproperty
  a_rxidx: assert property (p_rxidx) // (R19)
    else $error("receive index did not step by 8");

  property p_rd_clear;
    (CE && EVT.rx_desc_off && !wr_ctrl) |=> !rd_q && !CTRL.rx_desc_ready;
  endproperty
  a_rd_clear: assert property (p_rd_clear) // (R9)
    else $error("descriptors-ready not cleared");

  property p_len_low;
    (PREADY && !PSLVERR) |-> (PRDATA[1:0] == 2'b00) ||
      ($past(PADDR) != OFS_LEN);
  endproperty
  a_len_low: assert property (p_len_low) // (R17)
    else $error("length low bits not zero");

  property p_ctrl_rsvd;
    (PREADY && $past(PADDR) == OFS_CTRL) |-> PRDATA[31:17] == 15'h0000;
  endproperty
  a_ctrl_rsvd: assert property (p_ctrl_rsvd) // (R22)
    else $error("reserved control bits not zero");

  property p_strip;
    (CE && wr_ctrl && PWDATA[BIT_PID]) |=>
      CTRL.strip_first && CTRL.strip_second;
  endproperty
  a_strip: assert property (p_strip) // (R5)
    else $error("protocol strip did not strip address byte");

endmodule

// ### src/sticky_flag.sv
// sticky status flag: hardware sets, software clears by writing one.
// assumes set and clr are single-cycle strobes on the same clock.
`timescale 1ns/100ps
module sticky_flag (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic set,
  input  wire logic clr,
  output logic      q
);
  logic q_d;

  // set beats clear so an event in the clearing cycle is kept
  always_comb begin
    q_d = q;
    if (ce) begin
      if (set) begin
        q_d = 1'b1;
      end else if (clr) begin
        q_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= 1'b0;
    end else begin
      q <= q_d;
    end
  end

  // (R13) set is sticky
  property p_flag_set;
    @(posedge clk) disable iff (rst) (ce && set) |=> q;
  endproperty
  a_flag_set: assert property (p_flag_set) // (R13)
    else $error("flag not set after event");

  // (R12) only a write of one clears
  property p_flag_hold;
    @(posedge clk) disable iff (rst) (q && !(ce && clr)) |=> q;
  endproperty
  a_flag_hold: assert property (p_flag_hold) // (R12)
    else $error("flag dropped without a clear");
endmodule

// ### src/sync2.sv
// two-stage synchroniser for asynchronous level inputs.
// assumes the destination clock is CLK; the first stage feeds only the second.
`timescale 1ns/100ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  // next values, frozen while the clock enable is low
  always_comb begin
    meta_d = ce ? d : meta_q;
    q_d    = ce ? meta_q : q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= meta_d;
      q      <= q_d;
    end
  end
endmodule

// ### verification/dma_channel_ctrl_test.sv
// self-checking bench for the dma channel control block.
// assumes one 100 MHz clock; the far side is the dma_far_model stand-in.
`timescale 1ns/100ps
module dma_channel_ctrl_test
  import dma_chan_pkg::*;
;
  // stimulus, valued at time zero
  logic        CLK = 1'b0, RST = 1'b1, CE = 1'b1;
  logic        PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic        TICK_IN = 1'b0, SW_TICK = 1'b0, RX_TC_VALID = 1'b0;
  time_code_t  RX_TC = 8'h00;
  logic [7:0]  RX_ADDR = 8'h00, NODE_ADDR = 8'h12, NODE_MASK = 8'h00;
  dma_event_t  req = '0;
  logic [3:0]  gap = 4'h0;
  // observed values and bookkeeping
  logic        PREADY, PSLVERR, TC_SEND, ADDR_MATCH, IRQ, CHAR_DONE, err;
  logic [31:0] PRDATA, q, txa, rxa;
  logic [24:0] MAX_LEN;
  time_code_t  TC_DATA, ts_v;
  dma_event_t  EVT;
  dma_ctrl_t   CTRL;
  int          fail_count = 0, checked = 0;
  int          irq_n = 0, ts_n = 0, ab_n = 0, n0 = 0;

  dma_channel_ctrl u_dut (.CLK(CLK), .RST(RST), .CE(CE), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA),
    .TICK_IN(TICK_IN), .SW_TICK(SW_TICK), .CHAR_DONE(CHAR_DONE),
    .RX_TC_VALID(RX_TC_VALID), .RX_TC(RX_TC), .TC_SEND(TC_SEND),
    .TC_DATA(TC_DATA), .EVT(EVT), .CTRL(CTRL), .MAX_LEN(MAX_LEN),
    .TX_DESC_ADDR(txa), .RX_DESC_ADDR(rxa), .RX_ADDR(RX_ADDR),
    .NODE_ADDR(NODE_ADDR), .NODE_MASK(NODE_MASK),
    .ADDR_MATCH(ADDR_MATCH), .IRQ(IRQ));

  dma_far_model u_far (.CLK(CLK), .RST(RST), .REQ(req), .GAP(gap),
    .EVT(EVT), .CHAR_DONE(CHAR_DONE));

  always #5 CLK = ~CLK;

  // one-cycle pulses are counted at the edge that ends them
  always @(posedge CLK) begin
    if (IRQ === 1'b1) irq_n++;
    if (CTRL.abort === 1'b1) ab_n++;
    if (TC_SEND === 1'b1) begin
      ts_n++;
      ts_v = TC_DATA;
    end
  end

  // verdict and end of run
  task automatic tally_and_finish();
    if (fail_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // lets n edges pass and lands just after the last one
  task automatic step(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  // setup, enable, then hold until ready is seen at an edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    PSEL = 1'b1;
    PWRITE = w;
    PADDR = a;
    PWDATA = d;
    step(1);
    PENABLE = 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 8);
    q = PRDATA;
    err = PSLVERR;
    if (PREADY !== 1'b1) begin
      fail_count++;
      tally_and_finish();
    end
    #1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    // an idle cycle keeps the next setup off this release
    step(1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  // one-cycle event request to the far-side model
  task automatic fire(input logic [9:0] v);
    req = dma_event_t'(v);
    step(1);
    req = '0;
    step(2);
  endtask

  // bounded wait for a time-code send after n0 was taken
  task automatic wait_send();
    for (int n = 0; n < 40 && ts_n == n0; n++) step(1);
    if (ts_n == n0) begin
      fail_count++;
      tally_and_finish();
    end
  endtask

  // reset values, field widths and reserved bits
  task automatic t_regs();
    logic [7:0]  ofs [5] = '{OFS_TIME, OFS_LEN, OFS_TXD, OFS_RXD, OFS_ADDR};
    logic [31:0] exp [5] = '{32'hff, 32'h1fffffc, 32'hfffffff0,
                             32'hfffffff8, 32'hffff};
    rd(OFS_TIME); chk(q, 32'h0);
    rd(OFS_CTRL); chk(q & ~32'h1c, 32'h0);
    rd(OFS_ADDR); chk(q, 32'hfe);
    rd(OFS_TXD); chk(q & 32'h3ff, 32'h0);
    rd(OFS_RXD); chk(q & 32'h3ff, 32'h0);
    rd(8'h34); chk(err, 1'b1);
    for (int i = 0; i < 5; i++) begin
      wr(ofs[i], 32'hffffffff);
      rd(ofs[i]); chk(q, exp[i]);
    end
    chk(MAX_LEN, 25'h1fffffc);
    wr(OFS_ADDR, 32'hfe);
  endtask

  // sticky flags and interrupt pulses, masked first
  task automatic t_flags();
    int b [4] = '{BIT_PKTIN, BIT_PKTOUT, BIT_INERR, BIT_OUTERR};
    wr(OFS_CTRL, 32'h0);
    n0 = irq_n;
    fire(10'h200);
    step(2); chk(irq_n - n0, 0);
    wr(OFS_CTRL, 32'h1c);
    for (int i = 0; i < 4; i++) begin
      n0 = irq_n;
      fire(10'h200 >> i);
      step(2); chk(irq_n - n0, 1);
      rd(OFS_CTRL); chk(q[b[i]], 1'b1);
      wr(OFS_CTRL, 32'h1c | (32'h1 << b[i]));
      rd(OFS_CTRL); chk(q[b[i]], 1'b0);
    end
  endtask

  // transmit kick, link fault halt and abort
  task automatic t_tx();
    wr(OFS_CTRL, 32'h1d);
    step(1); chk(CTRL.tx_enable, 1'b1);
    fire(10'h008);
    rd(OFS_CTRL); chk(q[BIT_KICK], 1'b0);
    wr(OFS_CTRL, 32'h1d);
    fire(10'h020);
    rd(OFS_CTRL); chk(q[BIT_KICK], 1'b1);
    wr(OFS_CTRL, 32'h1001d);
    fire(10'h020);
    rd(OFS_CTRL); chk(q[BIT_KICK], 1'b0);
    n0 = ab_n;
    wr(OFS_CTRL, 32'h21d);
    step(2); chk(ab_n - n0, 1);
    rd(OFS_CTRL); chk(q & 32'h201, 32'h0);
  endtask

  // descriptor index steps and wraps, base untouched
  task automatic t_idx();
    wr(OFS_TXD, 32'hffffffe0);
    fire(10'h010);
    rd(OFS_TXD); chk(q, 32'hfffffff0);
    fire(10'h010);
    rd(OFS_TXD); chk(q, 32'hfffffc00);
    chk(txa, 32'hfffffc00);
    wr(OFS_RXD, 32'hfffffff0);
    fire(10'h004);
    rd(OFS_RXD); chk(q, 32'hfffffff8);
    chk(rxa, 32'hfffffff8);
    fire(10'h004);
    rd(OFS_RXD); chk(q, 32'hfffffc00);
  endtask

  // receive-side controls handed to the engines
  task automatic t_ctrl();
    wr(OFS_CTRL, 32'h801c);
    step(1); chk(CTRL.strip_first, 1'b1);
    chk(CTRL.strip_second, 1'b1);
    wr(OFS_CTRL, 32'h401c);
    step(1); chk(CTRL.strip_first, 1'b1);
    chk(CTRL.strip_second, 1'b0);
    chk(CTRL.discard_no_desc, 1'b1);
    wr(OFS_CTRL, 32'h181e);
    step(1); chk(CTRL.discard_no_desc, 1'b0);
    chk(CTRL.rx_enable, 1'b1);
    chk(CTRL.rx_desc_ready, 1'b1);
    fire(10'h002);
    rd(OFS_CTRL); chk(q[BIT_RD], 1'b0);
    req = dma_event_t'(10'h001);
    step(3);
    rd(OFS_CTRL); chk(q[BIT_RX], 1'b1);
    req = '0;
    step(3);
    rd(OFS_CTRL); chk(q[BIT_RX], 1'b0);
    wr(OFS_CTRL, 32'h1c);
    step(1); chk(CTRL.rx_enable, 1'b0);
  endtask

  task automatic am(input logic [7:0] a, input logic e);
    RX_ADDR = a;
    step(2);
    chk(ADDR_MATCH, e);
  endtask

  // node-wide versus own address, then masked compare
  task automatic t_addr();
    am(8'h12, 1'b1);
    am(8'hfe, 1'b0);
    wr(OFS_CTRL, 32'h201c);
    am(8'hfe, 1'b1);
    am(8'h12, 1'b0);
    wr(OFS_ADDR, 32'h0f35);
    am(8'h3a, 1'b1);
    am(8'h25, 1'b0);
  endtask

  // silent write, software tick, received code, pin tick on a slow link
  task automatic t_time();
    n0 = ts_n;
    wr(OFS_TIME, 32'hbe);
    step(12); chk(ts_n - n0, 0);
    SW_TICK = 1'b1;
    step(1);
    SW_TICK = 1'b0;
    wait_send(); chk(ts_v, 8'hbf);
    rd(OFS_TIME); chk(q, 32'hbf);
    RX_TC = 8'h55;
    RX_TC_VALID = 1'b1;
    step(1);
    RX_TC_VALID = 1'b0;
    rd(OFS_TIME); chk(q, 32'h55);
    gap = 4'h7;
    n0 = ts_n;
    TICK_IN = 1'b1;
    wait_send(); chk(ts_v, 8'h56);
    TICK_IN = 1'b0;
    // a tick while the clock enable is low must be ignored
    CE = 1'b0;
    SW_TICK = 1'b1;
    step(1);
    SW_TICK = 1'b0;
    CE = 1'b1;
    rd(OFS_TIME); chk(q, 32'h56);
  endtask

  // main sequence: reset held two cycles, then the scenarios
  initial begin
    step(2);
    RST = 1'b0;
    t_regs();
    t_flags();
    t_tx();
    t_idx();
    t_ctrl();
    t_addr();
    t_time();
    tally_and_finish();
  end
endmodule

// ### verification/dma_far_model.sv
// stand-in for the dma engines and the codec beside the channel control.
// assumes the bench asks for events one cycle ahead on the same clock.
`timescale 1ns/100ps
module dma_far_model
  import dma_chan_pkg::*;
(
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       RST,
  // requests from the bench
  input  dma_event_t      REQ,
  input  wire logic [3:0] GAP,
  // toward the channel control
  output dma_event_t      EVT,
  output logic            CHAR_DONE
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;

  // character timer: a long gap stands for a slow link
  always_comb begin
    cnt_d = (cnt_q >= GAP) ? 4'h0 : cnt_q + 4'h1;
  end

  // events leave one edge after the request, like registered engines
  always_ff @(posedge CLK) begin
    if (RST) begin
      cnt_q <= 4'h0;
      EVT   <= '0;
    end else begin
      cnt_q <= cnt_d;
      EVT   <= REQ;
    end
  end

  // a character ends when the timer reaches the gap
  assign CHAR_DONE = (cnt_q == GAP);
endmodule
